// file: pgp_pkg.sv
/*
 * Constants shared by the port 1 pin-select block: register offsets,
 * reset values, field positions and the synchroniser depth.
 * Assumes a 32-bit APB with byte addresses; registers sit in the low byte.
 */
package pgp_pkg;
    localparam int unsigned NPIN = 8;
    localparam logic [15:0] OFF_FUNC_SEL = 16'hffc8;
    localparam logic [15:0] OFF_DATA = 16'hffd4;
    localparam logic [15:0] OFF_PULLUP = 16'hffe0;
    localparam logic [15:0] OFF_DIR = 16'hffe4;
    localparam logic [7:0] RST_FUNC_SEL = 8'h10;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hff;
    localparam int unsigned BIT_EXT_INT3 = 7;
    localparam int unsigned BIT_EXT_INT2 = 6;
    localparam int unsigned BIT_EXT_INT1 = 5;
    localparam int unsigned BIT_RESERVED = 4;
    localparam int unsigned BIT_CAPTURE = 3;
    localparam int unsigned BIT_CMP_HIGH = 2;
    localparam int unsigned BIT_CMP_LOW = 1;
    localparam int unsigned BIT_TCLK_OUT = 0;
    // Mask of mode bits that pick an output alternate function
    localparam logic [7:0] ALT_OUT_MASK = 8'h07;
    localparam int unsigned SYNC_STAGES = 3;
endpackage : pgp_pkg

// file: pgp_pin_sync.sv
/*
 * Three-flop synchroniser for the eight pin inputs with agreement filter.
 * Assumes asynchronous pin levels; output changes once stages 2 and 3 agree.
 */
module pgp_pin_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] pin_async,
    output logic [7:0] pin_level
);
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s3_r;
    logic [7:0] lvl_r;
    logic [7:0] lvl_nxt;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_comb begin
                lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= 8'h00;
            s2_r <= 8'h00;
            s3_r <= 8'h00;
            lvl_r <= 8'h00;
        end else begin
            s1_r <= pin_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign pin_level = lvl_r;
endmodule : pgp_pin_sync

// file: pgp_pin_mux.sv
/*
 * Per-pin output mux: general I/O or the selected alternate function.
 * Assumes registered inputs; purely combinational, the top registers results.
 */
module pgp_pin_mux (
    input wire logic [7:0] func_sel,
    input wire logic [7:0] dir,
    input wire logic [7:0] data,
    input wire logic [7:0] pull_ctl,
    input wire logic [7:0] alt_out,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_pu
);
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            always_comb begin
                if (pgp_pkg::ALT_OUT_MASK[g] && func_sel[g]) begin
                    pin_out[g] = alt_out[g];
                    pin_oe_n[g] = 1'b0;
                    pin_pu[g] = 1'b0;
                end else if (func_sel[g] && g != pgp_pkg::BIT_RESERVED) begin
                    pin_out[g] = 1'b0;
                    pin_oe_n[g] = 1'b1;
                    pin_pu[g] = 1'b0;
                end else begin
                    pin_out[g] = data[g];
                    pin_oe_n[g] = ~dir[g];
                    pin_pu[g] = ~dir[g] & pull_ctl[g];
                end
            end
        end
    endgenerate
endmodule : pgp_pin_mux

// file: pgp_port1.sv
/*
 * Port 1 general I/O with pin function select, APB register slave.
 * Assumes a 50 MHz CLK_SYS, synchronous active-high SRST, pins resolved
 * by the pad from output, enable (low = drive) and pull-up request.
 */
// Design decision made here: the APB interface to the registers.
module pgp_port1 (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE_N,
    output logic [7:0] PIN_PULLUP,
    input wire logic CMP_HIGH_OUT,
    input wire logic CMP_LOW_OUT,
    input wire logic TIMER_CLK_OUT,
    output logic EXT_INT3_IN,
    output logic EXT_INT2_IN,
    output logic EXT_INT1_IN,
    output logic CAPTURE_IN,
    output logic TIMER_EVENT_INPUT
);
    typedef enum logic [0:0] {PGP_IDLE, PGP_ACCESS} pgp_apb_e;

    logic [7:0] func_sel_r, func_sel_nxt;
    logic [7:0] data_r, data_nxt;
    logic [7:0] pullup_r, pullup_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    pgp_apb_e st_r, st_nxt;
    logic [7:0] pin_out_r, pin_oe_n_r, pin_pu_r;
    logic [7:0] mux_out, mux_oe_n, mux_pu;
    logic [4:0] alt_in_r, alt_in_nxt;
    logic [7:0] pin_level;
    logic [7:0] port_read;
    logic [7:0] alt_out;
    logic [7:0] rd_byte;
    logic hit;
    logic wr_go;

    pgp_pin_sync u_sync (
        .clk(CLK_SYS),
        .srst(SRST),
        .pin_async(PIN_IN),
        .pin_level(pin_level)
    );

    assign alt_out = {5'h00, CMP_HIGH_OUT, CMP_LOW_OUT, TIMER_CLK_OUT};

    pgp_pin_mux u_mux (
        .func_sel(func_sel_r),
        .dir(dir_r),
        .data(data_r),
        .pull_ctl(pullup_r),
        .alt_out(alt_out),
        .pin_out(mux_out),
        .pin_oe_n(mux_oe_n),
        .pin_pu(mux_pu)
    );

    // Port read view per bit
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rd
            always_comb begin
                port_read[g] = dir_r[g] ? data_r[g] : pin_level[g];
            end
        end
    endgenerate

    // APB decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (PADDR)
            pgp_pkg::OFF_FUNC_SEL: rd_byte = func_sel_r | pgp_pkg::RST_FUNC_SEL;
            pgp_pkg::OFF_DATA: rd_byte = port_read;
            pgp_pkg::OFF_PULLUP: rd_byte = pullup_r;
            pgp_pkg::OFF_DIR: rd_byte = pgp_pkg::DIR_READ_VALUE;
            default: hit = 1'b0;
        endcase
    end

    // Two-cycle APB slave: pready one cycle after access phase begins
    always_comb begin
        st_nxt = st_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        wr_go = 1'b0;
        case (st_r)
            PGP_IDLE: begin
                if (PSEL && PENABLE) begin
                    st_nxt = PGP_ACCESS;
                    pready_nxt = 1'b1;
                    pslverr_nxt = ~hit;
                    prdata_nxt = (!PWRITE && hit) ? {24'h000000, rd_byte} : 32'h00000000;
                end
            end
            PGP_ACCESS: begin
                st_nxt = PGP_IDLE;
                wr_go = PSEL && PENABLE && PWRITE && hit && PSTRB[0];
            end
            default: st_nxt = PGP_IDLE;
        endcase
    end

    // Register writes take effect at the completing edge
    always_comb begin
        func_sel_nxt = func_sel_r;
        data_nxt = data_r;
        pullup_nxt = pullup_r;
        dir_nxt = dir_r;
        if (wr_go) begin
            case (PADDR)
                pgp_pkg::OFF_FUNC_SEL: func_sel_nxt = PWDATA[7:0] | pgp_pkg::RST_FUNC_SEL;
                pgp_pkg::OFF_DATA: data_nxt = PWDATA[7:0];
                pgp_pkg::OFF_PULLUP: pullup_nxt = PWDATA[7:0];
                pgp_pkg::OFF_DIR: dir_nxt = PWDATA[7:0];
                default: dir_nxt = dir_r;
            endcase
        end
    end

    // Alternate inputs follow the pin only while selected; else idle high
    always_comb begin
        alt_in_nxt[4] = func_sel_r[pgp_pkg::BIT_EXT_INT3] ? pin_level[7] : 1'b1;
        alt_in_nxt[3] = func_sel_r[pgp_pkg::BIT_EXT_INT2] ? pin_level[6] : 1'b1;
        alt_in_nxt[2] = func_sel_r[pgp_pkg::BIT_EXT_INT1] ? pin_level[5] : 1'b1;
        alt_in_nxt[1] = func_sel_r[pgp_pkg::BIT_CAPTURE] ? pin_level[3] : 1'b1;
        alt_in_nxt[0] = alt_in_nxt[4];
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            func_sel_r <= pgp_pkg::RST_FUNC_SEL;
            data_r <= pgp_pkg::RST_DATA;
            pullup_r <= pgp_pkg::RST_PULLUP;
            dir_r <= pgp_pkg::RST_DIR;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            st_r <= PGP_IDLE;
            pin_out_r <= 8'h00;
            pin_oe_n_r <= 8'hff;
            pin_pu_r <= 8'h00;
            alt_in_r <= 5'h1f;
        end else begin
            func_sel_r <= func_sel_nxt;
            data_r <= data_nxt;
            pullup_r <= pullup_nxt;
            dir_r <= dir_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            st_r <= st_nxt;
            pin_out_r <= mux_out;
            pin_oe_n_r <= mux_oe_n;
            pin_pu_r <= mux_pu;
            alt_in_r <= alt_in_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE_N = pin_oe_n_r;
    assign PIN_PULLUP = pin_pu_r;
    assign EXT_INT3_IN = alt_in_r[4];
    assign EXT_INT2_IN = alt_in_r[3];
    assign EXT_INT1_IN = alt_in_r[2];
    assign CAPTURE_IN = alt_in_r[1];
    assign TIMER_EVENT_INPUT = alt_in_r[0];

    // Assertions
    property p_data_reset;
        @(posedge CLK_SYS) SRST |=> (data_r == 8'h00 && dir_r == 8'h00 && func_sel_r == 8'h10);
    endproperty
    a_data_reset: assert property (p_data_reset) else $error("reset values wrong");

    property p_rd_out;
        @(posedge CLK_SYS) disable iff (SRST)
        (st_r == PGP_IDLE && PSEL && PENABLE && !PWRITE && PADDR == 16'hffd4)
        |=> PRDATA[7:0] == (($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(pin_level)));
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("port read mismatch");

    property p_rd_in;
        @(posedge CLK_SYS) disable iff (SRST)
        (st_r == PGP_IDLE && PSEL && PENABLE && !PWRITE && PADDR == 16'hffd4 && dir_r == 8'h00)
        |=> PRDATA[7:0] == $past(pin_level);
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("input read mismatch");

    property p_drive;
        @(posedge CLK_SYS) disable iff (SRST)
        dir_r[4] |=> (!PIN_OE_N[4] && PIN_OUT[4] == $past(data_r[4]));
    endproperty
    a_drive: assert property (p_drive) else $error("gpio drive wrong");

    property p_alt_in_hiz;
        @(posedge CLK_SYS) disable iff (SRST) func_sel_r[6] |=> PIN_OE_N[6];
    endproperty
    a_alt_in_hiz: assert property (p_alt_in_hiz) else $error("alt input pin driven");

    property p_dir_read;
        @(posedge CLK_SYS) disable iff (SRST)
        (st_r == PGP_IDLE && PSEL && PENABLE && !PWRITE && PADDR == 16'hffe4) |=> PRDATA == 32'h000000ff;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read not ones");

    property p_pullup;
        @(posedge CLK_SYS) disable iff (SRST)
        (func_sel_r[0] == 1'b0) |=> PIN_PULLUP[0] == (!$past(dir_r[0]) && $past(pullup_r[0]));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up wrong");

    property p_reserved;
        @(posedge CLK_SYS) disable iff (SRST) func_sel_r[4];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit cleared");

    property p_cmp_out;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[2] |=> (!PIN_OE_N[2] && PIN_OUT[2] == $past(CMP_HIGH_OUT));
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("compare output not routed");

    property p_int2;
        @(posedge CLK_SYS) disable iff (SRST) func_sel_r[6] |=> EXT_INT2_IN == $past(pin_level[6]);
    endproperty
    a_int2: assert property (p_int2) else $error("int2 input not routed");

    property p_ready;
        @(posedge CLK_SYS) disable iff (SRST) (st_r == PGP_IDLE && PSEL && PENABLE) |=> PREADY ##1 !PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready timing");

    property p_data_write;
        @(posedge CLK_SYS) disable iff (SRST)
        (wr_go && PADDR == pgp_pkg::OFF_DATA) |=> data_r == $past(PWDATA[7:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data latch write lost");

    property p_dir_reset;
        @(posedge CLK_SYS)
        SRST |=> (dir_r == pgp_pkg::RST_DIR && PIN_OE_N == 8'hff);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");

    property p_func_read;
        @(posedge CLK_SYS) disable iff (SRST)
        (st_r == PGP_IDLE && PSEL && PENABLE && !PWRITE && PADDR == pgp_pkg::OFF_FUNC_SEL) |=> PRDATA[4];
    endproperty
    a_func_read: assert property (p_func_read) else $error("reserved bit read as zero");

    property p_int1;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[5] |=> (EXT_INT1_IN == $past(pin_level[5]) && PIN_OE_N[5]);
    endproperty
    a_int1: assert property (p_int1) else $error("int1 input not routed");

    property p_capture;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[3] |=> (CAPTURE_IN == $past(pin_level[3]) && PIN_OE_N[3]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture input not routed");

    property p_int3;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[7] |=> (EXT_INT3_IN == $past(pin_level[7]) && TIMER_EVENT_INPUT == $past(pin_level[7]));
    endproperty
    a_int3: assert property (p_int3) else $error("int3 input not routed");

    property p_cmp_low;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[1] |=> (!PIN_OE_N[1] && PIN_OUT[1] == $past(CMP_LOW_OUT));
    endproperty
    a_cmp_low: assert property (p_cmp_low) else $error("low compare output not routed");

    property p_tclk_out;
        @(posedge CLK_SYS) disable iff (SRST)
        func_sel_r[0] |=> (!PIN_OE_N[0] && PIN_OUT[0] == $past(TIMER_CLK_OUT));
    endproperty
    a_tclk_out: assert property (p_tclk_out) else $error("timer clock output not routed");

    c_write_dir: cover property (@(posedge CLK_SYS) wr_go && PADDR == 16'hffe4);
    c_alt_out: cover property (@(posedge CLK_SYS) func_sel_r[1] && !PIN_OE_N[1]);
    c_int3: cover property (@(posedge CLK_SYS) func_sel_r[7] && !EXT_INT3_IN);
    c_err: cover property (@(posedge CLK_SYS) PSLVERR);
endmodule : pgp_port1

// file: pgp_pad_model.sv
/*
 * Pad model for port 1: resolves each pin level from the block's driver,
 * its pull-up request and an external source set by the bench.
 * Assumes an enable low means the block drives the pin.
 */
module pgp_pad_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pu,
    input wire logic [7:0] ext_lvl,
    output logic [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // Driver wins, then the pull-up, then whatever the board puts on the pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : (pin_pu[i] | ext_lvl[i]);
        end
    end
endmodule : pgp_pad_model

// file: pgp_port1_test.sv
/*
 * Self-checking bench for pgp_port1: APB master, pad model, reference model.
 * Assumes registers answer over APB and pin effects settle within eight cycles.
 */
module pgp_port1_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, srst, psel, penable, pwrite, cmp_h, cmp_l, tclk, er;
    logic pready, pslverr, ei3, ei2, ei1, cap, tev;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0] pstrb;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pu, ext;
    logic [7:0] f_m, d_m, p_m, c_m, oe_m, o_m, pu_m, lv_m;
    logic [15:0] adr [5];
    int n_errors = 0;
    int samples_checked = 0;
    int k;
    logic [3:0] sb;

    pgp_port1 u_pgp_port1 (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .PIN_PULLUP(pin_pu), .CMP_HIGH_OUT(cmp_h), .CMP_LOW_OUT(cmp_l),
        .TIMER_CLK_OUT(tclk), .EXT_INT3_IN(ei3), .EXT_INT2_IN(ei2), .EXT_INT1_IN(ei1),
        .CAPTURE_IN(cap), .TIMER_EVENT_INPUT(tev));
    pgp_pad_model u_pgp_pad_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
        .ext_lvl(ext), .pin_lvl(pin_in));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Reference pin behaviour from the four model registers
    always_comb begin
        oe_m = ~c_m;
        o_m = d_m;
        pu_m = p_m & ~c_m;
        for (int i = 0; i < 8; i++) begin
            if (f_m[i] && i < 3) begin
                oe_m[i] = 1'b0;
                o_m[i] = (i == 2) ? cmp_h : ((i == 1) ? cmp_l : tclk);
            end else if (f_m[i] && i != 4) begin
                oe_m[i] = 1'b1;
            end
            if (f_m[i] && i != 4) begin
                pu_m[i] = 1'b0;
            end
            lv_m[i] = !oe_m[i] ? o_m[i] : (pu_m[i] | ext[i]);
        end
    end

    task automatic end_sim();
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t bus got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bus

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            end_sim();
        end
    endtask : apb

    function automatic logic [31:0] exp_rd(input int i);
        case (i)
            0: return {24'h0, f_m};
            1: return {24'h0, (c_m & d_m) | (~c_m & lv_m)};
            2: return {24'h0, p_m};
            3: return {24'h0, pgp_pkg::DIR_READ_VALUE};
            default: return 32'h0;
        endcase
    endfunction : exp_rd

    // Reads every register and compares pins and routed inputs with the model
    task automatic check_all();
        repeat (8) @(posedge clk_sys);
        chk_pin(pin_oe_n, oe_m);
        chk_pin(pin_out & ~oe_m, o_m & ~oe_m);
        chk_pin(pin_pu, pu_m);
        chk_pin({3'h0, ei3, ei2, ei1, cap, tev}, {3'h0, lv_m[7] | ~f_m[7], lv_m[6] | ~f_m[6],
            lv_m[5] | ~f_m[5], lv_m[3] | ~f_m[3], lv_m[7] | ~f_m[7]});
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, adr[i], 32'h0, 4'h0);
            chk_bus(rd, exp_rd(i));
            chk_bus({31'h0, er}, {31'h0, i == 4});
        end
    endtask : check_all

    initial begin
        adr = '{pgp_pkg::OFF_FUNC_SEL, pgp_pkg::OFF_DATA, pgp_pkg::OFF_PULLUP, pgp_pkg::OFF_DIR, 16'hffd8};
        void'($urandom(32'he785));
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {cmp_h, cmp_l, tclk} = 3'h0;
        ext = 8'h5a;
        srst = 1'b1;
        f_m = pgp_pkg::RST_FUNC_SEL;
        d_m = pgp_pkg::RST_DATA;
        p_m = pgp_pkg::RST_PULLUP;
        c_m = pgp_pkg::RST_DIR;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        check_all();
        $display("test reset_values done");
        for (int it = 0; it < 40; it++) begin
            k = $urandom_range(0, 4);
            v = {$urandom} & 32'h0000_00ff;
            sb = 4'($urandom_range(0, 15)) | 4'($urandom_range(0, 3) != 0);
            ext <= 8'($urandom);
            {cmp_h, cmp_l, tclk} <= 3'($urandom);
            apb(1'b1, adr[k], v | 32'hab00_0000, sb);
            if (sb[0] && k < 4) begin
                case (k)
                    0: f_m = v[7:0] | 8'h10;
                    1: d_m = v[7:0];
                    2: p_m = v[7:0];
                    default: c_m = v[7:0];
                endcase
            end
            chk_bus({31'h0, er}, {31'h0, k == 4});
            check_all();
        end
        $display("test random_access done");
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        f_m = pgp_pkg::RST_FUNC_SEL;
        d_m = pgp_pkg::RST_DATA;
        p_m = pgp_pkg::RST_PULLUP;
        c_m = pgp_pkg::RST_DIR;
        check_all();
        $display("test mid_reset done");
        end_sim();
    end
endmodule : pgp_port1_test
